// ==== dbd_steer.sv ====
// dbd_steer: sector buffer steering, byte-lane selection and bus dma pacing.
// assumes apb master on CLK_IN; the disk and bus pin inputs are asynchronous to CLK_IN.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module dbd_steer (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic IRQ_OUT,
  // disk controller side
  input wire logic BUFFER_SELECT_IN,
  input wire logic DISK_BUFFER_REQUEST_IN,
  input wire logic BYTE_STEP_N_IN,
  output logic BANK0_EVEN_SEL_N_OUT,
  output logic BANK0_ODD_SEL_N_OUT,
  output logic BANK1_EVEN_SEL_N_OUT,
  output logic BANK1_ODD_SEL_N_OUT,
  output logic DISK_LOW_PATH_EN_N_OUT,
  output logic DISK_HIGH_PATH_EN_N_OUT,
  output logic DISK_TO_BUFFER_DIR_N_OUT,
  output logic UPPER_BANK_FLAG_OUT,
  // system bus side
  input wire logic BUS_DMA_ACK_N_IN,
  output logic BUS_DMA_REQ_N_OUT,
  output logic BUS_LOW_BYTE_EN_N_OUT,
  output logic BUS_HIGH_BYTE_EN_N_OUT,
  output logic ADDR_DRIVE_EN_N_OUT,
  output logic [7:0] BUS_EXT_ADDR_OUT,
  output logic BUS_HIGH_BYTE_ENABLE_OUT,
  output logic WORD_TICK_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // state record

  typedef struct packed {
    // synchronisers: stage 1 feeds stage 2 only
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic step_n_d;
    // sequencer pacing
    logic [4:0] div;
    logic seq_tick;
    dbd_pkg::dbd_state_t state;
    logic start_flag;
    logic bus_phase;
    // configuration
    logic disk_read;
    logic [6:0] ext_addr;
    logic [15:0] total_cfg;
    logic [15:0] burst_cfg;
    logic [15:0] delay_cfg;
    // working counters
    logic [15:0] total_cnt;
    logic [15:0] burst_cnt;
    logic [15:0] delay_cnt;
    logic odd;
    logic [11:0] waddr;
    // interrupt
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    // registered outputs
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [3:0] ram_sel_n;
    logic disk_low_n;
    logic disk_high_n;
    logic dir_n;
    logic req_n;
    logic bus_low_n;
    logic bus_high_n;
    logic aen_n;
    logic [7:0] ext_out;
    logic bhe;
    logic word_tick;
  } dbd_regs_t;

  dbd_regs_t cur_r;
  dbd_regs_t cur_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // one four-bit counter stage with carry in and carry out
  function automatic logic [4:0] nib_inc(input logic [3:0] v, input logic cin);
    logic [4:0] s;
    s = {1'b0, v} + {4'h0, cin};
    return s;
  endfunction : nib_inc

  // cascade of three stages, as wide as the 4K-word buffer
  function automatic logic [11:0] waddr_inc(input logic [11:0] v, input logic en);
    logic [4:0] s0;
    logic [4:0] s1;
    logic [4:0] s2;
    s0 = nib_inc(v[3:0], en);
    s1 = nib_inc(v[7:4], s0[4]);
    s2 = nib_inc(v[11:8], s1[4]);
    return {s2[3:0], s1[3:0], s0[3:0]};
  endfunction : waddr_inc

  // down counter that stops at zero
  function automatic logic [15:0] dec16(input logic [15:0] v);
    return (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
  endfunction : dec16

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic bsel;
    logic breq;
    logic step_n;
    logic ack;
    logic step_fall;
    logic wstep;
    logic bus_path;
    logic acc;
    logic wr;
    logic rd;
    logic [2:0] ev;
    logic [2:0] clr;
    logic start_wr;
    logic [3:0] sel;
    logic bank;
    logic [31:0] rdata;
    logic hit;
    bsel = 1'b0;
    breq = 1'b0;
    step_n = 1'b1;
    ack = 1'b0;
    step_fall = 1'b0;
    wstep = 1'b0;
    bus_path = 1'b0;
    acc = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    ev = 3'h0;
    clr = 3'h0;
    start_wr = 1'b0;
    sel = 4'h0;
    bank = 1'b0;
    rdata = 32'h0000_0000;
    hit = 1'b1;
    cur_nxt = cur_r;

    // pin synchronisers, then only stage 2 is looked at
    cur_nxt.sync1 = {BUS_DMA_ACK_N_IN, BYTE_STEP_N_IN, DISK_BUFFER_REQUEST_IN,
                     BUFFER_SELECT_IN};
    cur_nxt.sync2 = cur_r.sync1;
    bsel = cur_r.sync2[0];
    breq = cur_r.sync2[1];
    step_n = cur_r.sync2[2];
    ack = ~cur_r.sync2[3];
    cur_nxt.step_n_d = step_n;
    step_fall = cur_r.step_n_d & ~step_n;

    // sequencer tick enable from the system clock
    cur_nxt.seq_tick = 1'b0;
    if (cur_r.div == dbd_pkg::SEQ_DIV_LAST) begin
      cur_nxt.div = 5'h00;
      cur_nxt.seq_tick = 1'b1;
    end else begin
      cur_nxt.div = cur_r.div + 5'h01;
    end

    // apb: setup then two-cycle access, write lands with pready
    acc = PSEL_IN & PENABLE_IN & ~cur_r.pready;
    wr = PSEL_IN & PENABLE_IN & cur_r.pready & PWRITE_IN;
    rd = acc & ~PWRITE_IN;
    cur_nxt.pready = acc;
    unique case (PADDR_IN)
      dbd_pkg::OFS_CTRL: rdata = {17'h0_0000, cur_r.ext_addr, 6'h00, cur_r.disk_read, 1'b0};
      dbd_pkg::OFS_TOTAL: rdata = {16'h0000, cur_r.total_cnt};
      dbd_pkg::OFS_BURST: rdata = {16'h0000, cur_r.burst_cfg};
      dbd_pkg::OFS_DELAY: rdata = {16'h0000, cur_r.delay_cfg};
      dbd_pkg::OFS_STATUS: rdata = {4'h0, cur_r.waddr, 12'h000, cur_r.odd, ack,
                                    ~cur_r.req_n, (cur_r.state != dbd_pkg::ST_IDLE)};
      dbd_pkg::OFS_IRQ_STAT: rdata = {29'h0000_0000, cur_r.irq_stat};
      dbd_pkg::OFS_IRQ_CLR: rdata = 32'h0000_0000; // write only
      dbd_pkg::OFS_IRQ_EN: rdata = {29'h0000_0000, cur_r.irq_en};
      default: hit = 1'b0;
    endcase
    cur_nxt.prdata = rd ? rdata : 32'h0000_0000;
    cur_nxt.pslverr = acc & ~hit;

    if (wr) begin
      unique case (PADDR_IN)
        dbd_pkg::OFS_CTRL: begin
          start_wr = PWDATA_IN[dbd_pkg::CTRL_START_BIT];
          cur_nxt.disk_read = PWDATA_IN[dbd_pkg::CTRL_DISK_READ_BIT];
          cur_nxt.ext_addr = PWDATA_IN[dbd_pkg::CTRL_EXT_MSB:dbd_pkg::CTRL_EXT_LSB];
        end
        dbd_pkg::OFS_TOTAL: cur_nxt.total_cfg = PWDATA_IN[15:0];
        dbd_pkg::OFS_BURST: cur_nxt.burst_cfg = PWDATA_IN[15:0];
        dbd_pkg::OFS_DELAY: cur_nxt.delay_cfg = PWDATA_IN[15:0];
        dbd_pkg::OFS_IRQ_CLR: clr = PWDATA_IN[2:0];
        dbd_pkg::OFS_IRQ_EN: cur_nxt.irq_en = PWDATA_IN[2:0];
        default: ;
      endcase
    end

    // sequencer: arm, request, word transfers, gap, repeat
    cur_nxt.word_tick = 1'b0;
    unique case (cur_r.state)
      dbd_pkg::ST_IDLE: begin
        if (start_wr) begin
          cur_nxt.start_flag = 1'b1;
          cur_nxt.total_cnt = cur_r.total_cfg;
          cur_nxt.burst_cnt = cur_r.burst_cfg;
          cur_nxt.waddr = 12'h000;
          cur_nxt.odd = 1'b0;
          cur_nxt.state = dbd_pkg::ST_ARM;
        end
      end
      dbd_pkg::ST_ARM: begin
        // request raised only on the following sequencer tick
        if (cur_r.seq_tick && cur_r.start_flag) begin
          cur_nxt.start_flag = 1'b0;
          cur_nxt.req_n = 1'b0;
          cur_nxt.state = dbd_pkg::ST_REQ;
        end
      end
      dbd_pkg::ST_REQ: begin
        if (ack) begin
          cur_nxt.bus_phase = 1'b0;
          cur_nxt.state = dbd_pkg::ST_XFER;
        end
      end
      dbd_pkg::ST_XFER: begin
        // two sequencer ticks per word: low byte lane then high lane
        if (cur_r.seq_tick && ack) begin
          cur_nxt.bus_phase = ~cur_r.bus_phase;
          if (cur_r.bus_phase) begin
            cur_nxt.word_tick = 1'b1;
            cur_nxt.total_cnt = dec16(cur_r.total_cnt);
            cur_nxt.burst_cnt = dec16(cur_r.burst_cnt);
            if (cur_r.total_cnt <= 16'h0001) begin
              ev[dbd_pkg::IRQ_END_BIT] = 1'b1;
              cur_nxt.req_n = 1'b1;
              cur_nxt.state = dbd_pkg::ST_IDLE;
            end else if (cur_r.burst_cnt <= 16'h0001) begin
              ev[dbd_pkg::IRQ_BURST_BIT] = 1'b1;
              cur_nxt.req_n = 1'b1;
              cur_nxt.burst_cnt = cur_r.burst_cfg;
              cur_nxt.delay_cnt = cur_r.delay_cfg;
              cur_nxt.state = dbd_pkg::ST_GAP;
            end
          end
        end
      end
      dbd_pkg::ST_GAP: begin
        // hold off the bus so other masters get their turn
        if (cur_r.seq_tick) begin
          if (cur_r.delay_cnt == 16'h0000) begin
            cur_nxt.req_n = 1'b0;
            cur_nxt.state = dbd_pkg::ST_REQ;
          end else begin
            cur_nxt.delay_cnt = cur_r.delay_cnt - 16'h0001;
          end
        end
      end
    endcase

    // byte steps from the disk side, word steps from either side
    if (step_fall) begin
      cur_nxt.odd = ~cur_r.odd;
    end
    wstep = (step_fall & cur_r.odd) | cur_nxt.word_tick;
    cur_nxt.waddr = waddr_inc(cur_nxt.waddr, wstep);
    if (wstep && cur_r.waddr == 12'h7FF) begin
      ev[dbd_pkg::IRQ_BANK_BIT] = 1'b1;
    end
    bank = cur_r.waddr[dbd_pkg::BANK_BIT];

    // chip and lane selects, decoded from buffer select, byte parity, bank, request, acknowledge and phase
    bus_path = ack & ~breq & (cur_r.state == dbd_pkg::ST_XFER);
    cur_nxt.disk_low_n = ~(bsel & ~cur_r.odd);
    cur_nxt.disk_high_n = ~(bsel & cur_r.odd);
    cur_nxt.bus_low_n = ~(bus_path & ~cur_r.bus_phase);
    cur_nxt.bus_high_n = ~(bus_path & cur_r.bus_phase);
    if (bsel) begin
      sel = {bank & cur_r.odd, bank & ~cur_r.odd, ~bank & cur_r.odd,
             ~bank & ~cur_r.odd};
    end else if (bus_path) begin
      sel = {bank & cur_r.bus_phase, bank & ~cur_r.bus_phase,
             ~bank & cur_r.bus_phase, ~bank & ~cur_r.bus_phase};
    end
    // sel order: bank0 even, bank0 odd, bank1 even, bank1 odd
    cur_nxt.ram_sel_n = ~sel;
    cur_nxt.dir_n = ~cur_r.disk_read;

    // address drive while acknowledged; word transfers keep bit 0 low
    cur_nxt.aen_n = ~ack;
    cur_nxt.ext_out = ack ? {cur_r.ext_addr, 1'b0} : 8'h00;
    cur_nxt.bhe = ack & (cur_r.state == dbd_pkg::ST_XFER);

    // sticky events: a set in the clear cycle survives
    cur_nxt.irq_stat = (cur_r.irq_stat & ~clr) | ev;
    cur_nxt.irq = |(cur_r.irq_stat & cur_r.irq_en);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // reset leaves every select and enable inactive
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      cur_r <= '0;
      cur_r.sync1 <= 4'hC;
      cur_r.sync2 <= 4'hC;
      cur_r.step_n_d <= 1'b1;
      cur_r.state <= dbd_pkg::ST_IDLE;
      cur_r.ext_addr <= dbd_pkg::EXT_RST;
      cur_r.total_cfg <= dbd_pkg::TOTAL_RST;
      cur_r.burst_cfg <= dbd_pkg::BURST_RST;
      cur_r.delay_cfg <= dbd_pkg::DELAY_RST;
      cur_r.ram_sel_n <= 4'hF;
      cur_r.disk_low_n <= 1'b1;
      cur_r.disk_high_n <= 1'b1;
      cur_r.dir_n <= 1'b1;
      cur_r.req_n <= 1'b1;
      cur_r.bus_low_n <= 1'b1;
      cur_r.bus_high_n <= 1'b1;
      cur_r.aen_n <= 1'b1;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign PRDATA_OUT = cur_r.prdata;
  assign PREADY_OUT = cur_r.pready;
  assign PSLVERR_OUT = cur_r.pslverr;
  assign IRQ_OUT = cur_r.irq;
  assign BANK0_EVEN_SEL_N_OUT = cur_r.ram_sel_n[0];
  assign BANK0_ODD_SEL_N_OUT = cur_r.ram_sel_n[1];
  assign BANK1_EVEN_SEL_N_OUT = cur_r.ram_sel_n[2];
  assign BANK1_ODD_SEL_N_OUT = cur_r.ram_sel_n[3];
  assign DISK_LOW_PATH_EN_N_OUT = cur_r.disk_low_n;
  assign DISK_HIGH_PATH_EN_N_OUT = cur_r.disk_high_n;
  assign DISK_TO_BUFFER_DIR_N_OUT = cur_r.dir_n;
  assign UPPER_BANK_FLAG_OUT = cur_r.waddr[dbd_pkg::BANK_BIT];
  assign BUS_DMA_REQ_N_OUT = cur_r.req_n;
  assign BUS_LOW_BYTE_EN_N_OUT = cur_r.bus_low_n;
  assign BUS_HIGH_BYTE_EN_N_OUT = cur_r.bus_high_n;
  assign ADDR_DRIVE_EN_N_OUT = cur_r.aen_n;
  assign BUS_EXT_ADDR_OUT = cur_r.ext_out;
  assign BUS_HIGH_BYTE_ENABLE_OUT = cur_r.bhe;
  assign WORD_TICK_OUT = cur_r.word_tick;

endmodule : dbd_steer

`default_nettype wire

// ==== dbd_pkg.sv ====
// dbd_pkg: shared constants for the disk buffer dma steering block.
// assumes a 50 MHz system clock and a 32-bit apb register bus.
package dbd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clocking
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SEQ_HZ = 2_000_000;
  // sequencer enable divider, 25 system cycles per sequencer tick
  localparam int unsigned SEQ_DIV = CLK_HZ / SEQ_HZ;
  localparam logic [4:0] SEQ_DIV_LAST = 5'(SEQ_DIV - 1);

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TOTAL = 8'h04;
  localparam logic [7:0] OFS_BURST = 8'h08;
  localparam logic [7:0] OFS_DELAY = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN = 8'h1C;

  ////////////////////////////////////////////////////////////////////////////
  // control fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DISK_READ_BIT = 1;
  localparam int CTRL_EXT_LSB = 8;
  localparam int CTRL_EXT_MSB = 14;

  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_REQ_BIT = 1;
  localparam int STAT_ACK_BIT = 2;
  localparam int STAT_ODD_BIT = 3;
  localparam int STAT_ADDR_LSB = 16;
  localparam int STAT_ADDR_MSB = 27;

  // interrupt bits
  localparam int IRQ_END_BIT = 0;
  localparam int IRQ_BURST_BIT = 1;
  localparam int IRQ_BANK_BIT = 2;
  localparam int IRQ_W = 3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [15:0] TOTAL_RST = 16'h0000;
  localparam logic [15:0] BURST_RST = 16'h0001;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [6:0] EXT_RST = 7'h00;

  // word address width: 4K words, bit 11 is the bank bit
  localparam int WADDR_W = 12;
  localparam int BANK_BIT = 11;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARM,
    ST_REQ,
    ST_XFER,
    ST_GAP
  } dbd_state_t;

endpackage : dbd_pkg

// ==== dbd_steer_asserts.sv ====
// dbd_steer_asserts: port checks for the steering block.
// assumes it is bound into dbd_steer and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dbd_steer_asserts (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic BUS_DMA_ACK_N_IN,
  input wire logic BUS_DMA_REQ_N_OUT,
  input wire logic BANK0_EVEN_SEL_N_OUT,
  input wire logic BANK0_ODD_SEL_N_OUT,
  input wire logic BANK1_EVEN_SEL_N_OUT,
  input wire logic BANK1_ODD_SEL_N_OUT,
  input wire logic DISK_LOW_PATH_EN_N_OUT,
  input wire logic DISK_HIGH_PATH_EN_N_OUT,
  input wire logic UPPER_BANK_FLAG_OUT,
  input wire logic BUS_LOW_BYTE_EN_N_OUT,
  input wire logic BUS_HIGH_BYTE_EN_N_OUT,
  input wire logic ADDR_DRIVE_EN_N_OUT,
  input wire logic [7:0] BUS_EXT_ADDR_OUT,
  input wire logic BUS_HIGH_BYTE_ENABLE_OUT,
  input wire logic WORD_TICK_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!NRST_IN);
  ////////////////////////////////
  // apb answer: one wait, one-cycle ready
  ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT) else $error("ready held");
  ready_wait_a: assert property (PREADY_OUT |-> PSEL_IN && PENABLE_IN && $past(PENABLE_IN))
    else $error("ready without wait");
  slverr_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT) else $error("lone error");
  // lanes never fight; a ram chip of bank 1 only with the bank flag
  chip_onehot_a:
    assert property ($onehot0(~{BANK0_EVEN_SEL_N_OUT, BANK0_ODD_SEL_N_OUT,
      BANK1_EVEN_SEL_N_OUT, BANK1_ODD_SEL_N_OUT})) else $error("two chips");
  disk_lane_a:
    assert property (DISK_LOW_PATH_EN_N_OUT || DISK_HIGH_PATH_EN_N_OUT) else $error("disk lanes");
  bank_sel_a:
    assert property (!(BANK1_EVEN_SEL_N_OUT && BANK1_ODD_SEL_N_OUT) |->
      $past(UPPER_BANK_FLAG_OUT))
    else $error("bank select");
  bus_lane_a:
    assert property (BUS_LOW_BYTE_EN_N_OUT || BUS_HIGH_BYTE_EN_N_OUT) else $error("bus lanes");
  // acknowledge is synchronised, so four low samples must have reached the drive
  ack_drive_a:
    assert property (!BUS_DMA_ACK_N_IN [*4] |-> !ADDR_DRIVE_EN_N_OUT) else $error("no drive");
  ack_release_a:
    assert property (BUS_DMA_ACK_N_IN [*4] |-> ADDR_DRIVE_EN_N_OUT) else $error("drive held");
  ext_idle_a:
    assert property (ADDR_DRIVE_EN_N_OUT |-> BUS_EXT_ADDR_OUT == 8'h00) else $error("ext addr");
  high_enable_a:
    assert property (BUS_HIGH_BYTE_ENABLE_OUT |-> !ADDR_DRIVE_EN_N_OUT) else $error("hbe");
  tick_pulse_a:
    assert property (WORD_TICK_OUT |=> !WORD_TICK_OUT) else $error("tick held");
  cover property ($fell(BUS_DMA_REQ_N_OUT));
  cover property (WORD_TICK_OUT);
  cover property (PSLVERR_OUT);
  cover property (!BANK1_EVEN_SEL_N_OUT);
endmodule : dbd_steer_asserts
bind dbd_steer dbd_steer_asserts i_chk (.CLK_IN, .NRST_IN, .PSEL_IN, .PENABLE_IN,
  .PREADY_OUT, .PSLVERR_OUT, .BUS_DMA_ACK_N_IN, .BUS_DMA_REQ_N_OUT, .BANK0_EVEN_SEL_N_OUT,
  .BANK0_ODD_SEL_N_OUT, .BANK1_EVEN_SEL_N_OUT, .BANK1_ODD_SEL_N_OUT,
  .DISK_LOW_PATH_EN_N_OUT, .DISK_HIGH_PATH_EN_N_OUT, .UPPER_BANK_FLAG_OUT,
  .BUS_LOW_BYTE_EN_N_OUT, .BUS_HIGH_BYTE_EN_N_OUT, .ADDR_DRIVE_EN_N_OUT,
  .BUS_EXT_ADDR_OUT, .BUS_HIGH_BYTE_ENABLE_OUT, .WORD_TICK_OUT);
`default_nettype wire

// ==== dbd_bus_master.sv ====
// dbd_bus_master: system bus dma master answering the block's request.
// assumes active low request and acknowledge on the block clock.
`timescale 1ns/1ps
`default_nettype none
module dbd_bus_master (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic req_n_in,
  input wire logic slow_in,
  output logic ack_n_out
);
  logic [3:0] wait_r;
  // grant after a short or long wait; drop at once when the request ends
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_n_out <= 1'b1;
      wait_r <= 4'h0;
    end else if (req_n_in) begin
      ack_n_out <= 1'b1;
      wait_r <= 4'h0;
    end else if (wait_r == (slow_in ? 4'hF : 4'h1)) begin
      ack_n_out <= 1'b0;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule : dbd_bus_master
`default_nettype wire

// ==== dbd_steer_tb.sv ====
// dbd_steer_tb: self-checking bench for the steering block.
// assumes dbd_bus_master and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module dbd_steer_tb;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, req_d = 1'b1;
  logic bsel = 1'b0, breq = 1'b0, step_n = 1'b1, slow = 1'b0;
  logic pready, pslverr, irq, dir_n, bank, ack_n, req_n, aen_n, hbe, tick;
  wire [1:0] dp_n, bp_n;
  logic [2:0] seen;
  wire [3:0] cs_n;
  logic [7:0] paddr = 8'h00, ext, exp_ext;
  logic [31:0] pwdata = 32'h0000_0000, prdata, seed = 32'h0000_93D8;
  logic [64:0] exp_q[$], q;
  int errors = 0, n_checks = 0, n_tick = 0, n_burst = 0, gap = 0, lim = 0, i;
  // 50 MHz clock
  always #10 clk = ~clk;
  ////////////////////////////////
  dbd_steer i_dut (.CLK_IN(clk), .NRST_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .IRQ_OUT(irq), .BUFFER_SELECT_IN(bsel),
    .DISK_BUFFER_REQUEST_IN(breq), .BYTE_STEP_N_IN(step_n),
    .BANK0_EVEN_SEL_N_OUT(cs_n[0]), .BANK0_ODD_SEL_N_OUT(cs_n[1]),
    .BANK1_EVEN_SEL_N_OUT(cs_n[2]), .BANK1_ODD_SEL_N_OUT(cs_n[3]),
    .DISK_LOW_PATH_EN_N_OUT(dp_n[0]), .DISK_HIGH_PATH_EN_N_OUT(dp_n[1]),
    .DISK_TO_BUFFER_DIR_N_OUT(dir_n), .UPPER_BANK_FLAG_OUT(bank),
    .BUS_DMA_ACK_N_IN(ack_n), .BUS_DMA_REQ_N_OUT(req_n), .BUS_LOW_BYTE_EN_N_OUT(bp_n[0]),
    .BUS_HIGH_BYTE_EN_N_OUT(bp_n[1]), .ADDR_DRIVE_EN_N_OUT(aen_n), .BUS_EXT_ADDR_OUT(ext),
    .BUS_HIGH_BYTE_ENABLE_OUT(hbe), .WORD_TICK_OUT(tick));
  dbd_bus_master i_bm (.clk_in(clk), .rst_n_in(rst_n), .req_n_in(req_n),
    .slow_in(slow), .ack_n_out(ack_n));
  ////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim();
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // one apb transfer; m is {slverr, read mask}, e the masked read value
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [32:0] m, input logic [31:0] e);
    int k;
    exp_q.push_back({m, e});
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (k = 0; k < 40 && pready !== 1'b1; k++) @(posedge clk);
    if (k == 40) begin
      errors++;
      end_sim();
    end
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  // byte step held long enough to cross the input synchronisers
  task automatic step();
    step_n <= 1'b0;
    repeat (3) @(posedge clk);
    step_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : step
  task automatic dma(input int tot, input int bur, input int dly, input logic rd);
    logic [31:0] cw;
    int k;
    cw = {17'h0_0000, 7'(xs()), 6'h00, rd, 1'b1};
    exp_ext = {cw[14:8], 1'b0};
    // gap runs delay plus one sequencer ticks of the free divider
    lim = (dly + 1) * int'(dbd_pkg::SEQ_DIV);
    apb(1'b1, dbd_pkg::OFS_TOTAL, 32'(tot), 33'h0, 32'h0);
    apb(1'b1, dbd_pkg::OFS_BURST, 32'(bur), 33'h0, 32'h0);
    apb(1'b1, dbd_pkg::OFS_DELAY, 32'(dly), 33'h0, 32'h0);
    apb(1'b1, dbd_pkg::OFS_IRQ_CLR, 32'h0000_0007, 33'h0, 32'h0);
    apb(1'b1, dbd_pkg::OFS_IRQ_EN, 32'h0000_0001, 33'h0, 32'h0);
    n_tick = 0;
    n_burst = 0;
    seen = 3'h0;
    apb(1'b1, dbd_pkg::OFS_CTRL, cw, 33'h0, 32'h0);
    for (k = 0; k < 30 && req_n === 1'b1; k++) @(posedge clk);
    chk("req_wait", 32'h1, {31'h0, k < 27});
    if (k == 30) end_sim();
    // a second start while busy must not disturb the counts
    apb(1'b1, dbd_pkg::OFS_CTRL, cw, 33'h0, 32'h0);
    chk("dir", {31'h0, !rd}, {31'h0, dir_n});
    for (k = 0; k < 20000 && irq !== 1'b1; k++) @(posedge clk);
    if (k == 20000) begin
      errors++;
      end_sim();
    end
    k = (bur == 0) ? 1 : bur;
    chk("words", 32'(tot), 32'(n_tick));
    chk("bursts", 32'((tot + k - 1) / k), 32'(n_burst));
    chk("lanes", 32'h7, {29'h0, seen});
    apb(1'b0, dbd_pkg::OFS_TOTAL, 32'h0, 33'h0_0000_FFFF, 32'h0);
  endtask : dma
  ////////////////////////////////
  // answer checker against the oldest note, plus dma tallies
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      q = exp_q.pop_front();
      chk("prdata", q[31:0], prdata & q[63:32]);
      chk("pslverr", {31'h0, q[64]}, {31'h0, pslverr});
    end
    if (tick === 1'b1) begin
      n_tick++;
      chk("ext_addr", {24'h0, exp_ext}, {24'h0, ext});
    end
    if (req_d === 1'b1 && req_n === 1'b0) begin
      if (n_burst > 0) chk("gap", 32'(lim), 32'(gap));
      n_burst++;
    end
    gap = req_n ? gap + 1 : 0;
    seen |= {hbe, !bp_n[1], !bp_n[0]};
    req_d <= req_n;
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    chk("rst_hi", 32'h0000_07FF, {21'h0, cs_n, dp_n, bp_n, dir_n, req_n, aen_n});
    chk("rst_lo", 32'h0, prdata | {19'h0, ext, bank, hbe, tick, irq, pready});
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 8; i++) apb(1'b0, 8'(i * 4), 32'h0, 33'h0_FFFF_FFFF, 32'(i == 2));
    apb(1'b1, dbd_pkg::OFS_IRQ_STAT, 32'hFFFF_FFFF, 33'h0, 32'h0);
    apb(1'b0, dbd_pkg::OFS_IRQ_STAT, 32'h0, 33'h0_FFFF_FFFF, 32'h0);
    apb(1'b0, 8'h20, 32'h0, 33'h1_FFFF_FFFF, 32'h0);
    breq <= 1'b1;
    bsel <= 1'b1;
    repeat (4) @(posedge clk);
    chk("even_lane", 32'h0000_003A, {26'h0, cs_n, dp_n});
    step();
    chk("odd_lane", 32'h0000_0035, {26'h0, cs_n, dp_n});
    step();
    apb(1'b0, dbd_pkg::OFS_STATUS, 32'h0, 33'h0_0FFF_0000, 32'h0001_0000);
    apb(1'b1, dbd_pkg::OFS_IRQ_EN, 32'h0000_0004, 33'h0, 32'h0);
    for (i = 0; i < 4094; i++) step();
    chk("bank1_even", 32'h0000_006E, {25'h0, bank, cs_n, dp_n});
    chk("irq_set", 32'h1, {31'h0, irq});
    apb(1'b1, dbd_pkg::OFS_IRQ_EN, 32'h0, 33'h0, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq_mask", 32'h0, {31'h0, irq});
    apb(1'b1, dbd_pkg::OFS_IRQ_CLR, 32'h0000_0004, 33'h0, 32'h0);
    apb(1'b0, dbd_pkg::OFS_IRQ_STAT, 32'h0, 33'h0_0000_0004, 32'h0);
    // disk side goes quiet, else its request keeps the bus lanes shut
    bsel <= 1'b0;
    breq <= 1'b0;
    dma(5, 2, 2, 1'b1);
    slow <= 1'b1;
    dma(3 + int'(xs() % 4), 0, 1, 1'b0);
    end_sim();
  end
endmodule : dbd_steer_tb
`default_nettype wire
